// ### common/txdc_cfg.svh
// register offsets, field positions and reset values of the deviation and
// post-transmit configuration; included by the design files only
`ifndef TXDC_CFG_SVH
`define TXDC_CFG_SVH
`define TXDC_DEV_OFS    6'h15
`define TXDC_RCC_OFS    6'h17
`define TXDC_DEV_E_LSB  4
`define TXDC_DEV_M_LSB  0
`define TXDC_TXOFF_LSB  0
`define TXDC_RSV_LSB    2
`define TXDC_DEV_E_RST  3'h4
`define TXDC_DEV_M_RST  3'h7
`define TXDC_TXOFF_RST  2'h0
`define TXDC_RSV_VAL    4'hc
`define TXDC_IMPL_ONE   4'h8
`endif

// ### common/txdc_pkg.sv
// types shared by the deviation and post-transmit configuration block
// assumes txdc_cfg.svh supplies all numeric constants
package txdc_pkg;
  typedef enum logic [2:0]
  {
    TXDC_MOD_FSK  = 3'h0,
    TXDC_MOD_GFSK = 3'h1,
    TXDC_MOD_ASK  = 3'h3,
    TXDC_MOD_MSK  = 3'h7
  } txdc_mod_t;

  typedef enum logic [1:0]
  {
    TXDC_NXT_IDLE  = 2'h0,
    TXDC_NXT_SYNTH = 2'h1,
    TXDC_NXT_TX    = 2'h2,
    TXDC_NXT_NONE  = 2'h3
  } txdc_next_t;

  typedef enum logic [1:0] {TXDC_ST_IDLE, TXDC_ST_SYNTH, TXDC_ST_TX} txdc_state_t;
endpackage

// ### common/txdc_cfg_if.sv
// configuration and modulator signals between control and modulator parts
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface txdc_cfg_if;
  logic [2:0]  dev_e;
  logic [2:0]  dev_m;
  logic [2:0]  mod_sel;
  logic        sym_tick;
  logic        eighth_tick;
  logic        data_bit;
  logic [10:0] dev_word;
  logic        dev_active;
  logic [1:0]  msk_phase;
  logic        msk_ramp;
  logic [3:0]  msk_frac;

  modport ctl
  (
    output dev_e, dev_m, mod_sel, sym_tick, eighth_tick, data_bit,
    input  dev_word, dev_active, msk_phase, msk_ramp, msk_frac
  );
  modport mod
  (
    input  dev_e, dev_m, mod_sel, sym_tick, eighth_tick, data_bit,
    output dev_word, dev_active, msk_phase, msk_ramp, msk_frac
  );
endinterface

// ### design/txdc_mod.sv
// deviation interpreter: turns exponent, mantissa and modulation format
// into fsk deviation word or msk phase steps; same clock as the control part
`timescale 1ns/10ps
`include "txdc_cfg.svh"
module txdc_mod
(
  input  wire logic clk,
  input  wire logic reset,
  txdc_cfg_if.mod   cfg
);
  typedef struct packed
  {
    logic [10:0] dev_word;
    logic        dev_active;
    logic [1:0]  phase;
    logic        ramp;
    logic [3:0]  frac;
    logic [2:0]  eighth;
  } txdc_mod_st_t;

  txdc_mod_st_t q, d;
  logic         is_fsk;
  logic         is_msk;
  logic [3:0]   mant4;

  // format decode and implicit leading one of the mantissa
  assign is_fsk = (cfg.mod_sel == txdc_pkg::TXDC_MOD_FSK) || (cfg.mod_sel == txdc_pkg::TXDC_MOD_GFSK);
  assign is_msk = (cfg.mod_sel == txdc_pkg::TXDC_MOD_MSK);
  assign mant4  = `TXDC_IMPL_ONE | {1'b0, cfg.dev_m};

  // next state: ask/ook and unused codes leave all outputs idle, only the eighth count still runs
  always_comb
  begin
    d = q;
    d.dev_word   = is_fsk ? (11'(mant4) << cfg.dev_e) : 11'h000;
    d.dev_active = is_fsk;
    d.frac       = is_msk ? 4'(cfg.dev_m) + 4'h1 : 4'h0;
    if (cfg.sym_tick)
    begin
      d.eighth = 3'h0;
    end
    else if (cfg.eighth_tick)
    begin
      d.eighth = q.eighth + 3'h1;
    end
    d.ramp = is_msk && ({1'b0, d.eighth} < d.frac);
    if (is_msk && cfg.sym_tick)
    begin
      d.phase = cfg.data_bit ? q.phase - 2'h1 : q.phase + 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign cfg.dev_word   = q.dev_word;
  assign cfg.dev_active = q.dev_active;
  assign cfg.msk_phase  = q.phase;
  assign cfg.msk_ramp   = q.ramp;
  assign cfg.msk_frac   = q.frac;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // fsk deviation word follows equation within one cycle
  property p_fsk_word;
    !reset && is_fsk |=> cfg.dev_word == (11'(`TXDC_IMPL_ONE | {1'b0, $past(cfg.dev_m)}) << $past(cfg.dev_e));
  endproperty
  a_fsk_word: assert property (p_fsk_word) else $error("fsk deviation word wrong");

  // mantissa msb is always one in fsk
  property p_impl_one;
    !reset && is_fsk ##1 $stable(cfg.dev_e) |-> cfg.dev_word[4'($past(cfg.dev_e)) + 4'h3];
  endproperty
  a_impl_one: assert property (p_impl_one) else $error("implicit one missing");

  // msk phase turns by a quarter per symbol, sign from data
  property p_msk_phase;
    is_msk && cfg.sym_tick |=> cfg.msk_phase == ($past(cfg.data_bit) ? $past(cfg.msk_phase) - 2'h1
                                                                      : $past(cfg.msk_phase) + 2'h1);
  endproperty
  a_msk_phase: assert property (p_msk_phase) else $error("msk phase step wrong");

  // phase change lasts mantissa+1 eighths of the symbol
  property p_msk_frac;
    !reset && is_msk ##1 is_msk
      |-> cfg.msk_frac == 4'($past(cfg.dev_m)) + 4'h1 && cfg.msk_ramp == (4'(q.eighth) < cfg.msk_frac);
  endproperty
  a_msk_frac: assert property (p_msk_frac) else $error("msk fraction wrong");

  // ask/ook ignores deviation settings
  property p_ask_quiet;
    cfg.mod_sel == txdc_pkg::TXDC_MOD_ASK |=> cfg.dev_word == 11'h000 && !cfg.msk_ramp && $stable(cfg.msk_phase);
  endproperty
  a_ask_quiet: assert property (p_ask_quiet) else $error("ask affected by deviation");
endmodule

// ### design/txdc_top.sv
// deviation setting and post-transmit next-state configuration registers,
// with the small radio state walk they steer; register port from the
// serial interface logic and all control inputs share clk
`timescale 1ns/10ps
`include "txdc_cfg.svh"
module txdc_top
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [5:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic [2:0]         modulation_select,
  input  wire logic               tx_start,
  input  wire logic               idle_cmd,
  input  wire logic               pkt_done,
  input  wire logic               sym_tick,
  input  wire logic               eighth_tick,
  input  wire logic               data_bit,
  output txdc_pkg::txdc_state_t   radio_state,
  output logic                    preamble_restart,
  output logic      [10:0]        dev_word,
  output logic                    dev_active,
  output logic      [1:0]         msk_phase,
  output logic                    msk_ramp
);
  typedef struct packed
  {
    logic [2:0]            dev_e;
    logic [2:0]            dev_m;
    logic [1:0]            txoff;
    txdc_pkg::txdc_state_t st;
    logic                  pre_rst;
    logic [7:0]            rdata;
  } txdc_top_st_t;

  txdc_top_st_t q, d;
  logic         wr_dev;
  logic         wr_rcc;
  txdc_cfg_if   cfg_if ();

  // register write decode
  assign wr_dev = reg_wr && (reg_addr == `TXDC_DEV_OFS);
  assign wr_rcc = reg_wr && (reg_addr == `TXDC_RCC_OFS);

  // configuration to the deviation interpreter
  assign cfg_if.dev_e       = q.dev_e;
  assign cfg_if.dev_m       = q.dev_m;
  assign cfg_if.mod_sel     = modulation_select;
  assign cfg_if.sym_tick    = sym_tick;
  assign cfg_if.eighth_tick = eighth_tick;
  assign cfg_if.data_bit    = data_bit;

  txdc_mod u_mod
  (
    .clk   (clk),
    .reset (reset),
    .cfg   (cfg_if.mod)
  );

  // next state of registers, read data and radio state
  always_comb
  begin
    d = q;
    d.pre_rst = 1'b0;
    // deviation register: bits 7 and 3 are not stored
    if (wr_dev)
    begin
      d.dev_e = reg_wdata[`TXDC_DEV_E_LSB +: 3];
      d.dev_m = reg_wdata[`TXDC_DEV_M_LSB +: 3];
    end
    // radio control register: only the next-state field is writable
    if (wr_rcc)
    begin
      d.txoff = reg_wdata[`TXDC_TXOFF_LSB +: 2];
    end
    // read mux, answered one cycle after the address
    case (reg_addr)
      `TXDC_DEV_OFS:
        d.rdata = {1'b0, q.dev_e, 1'b0, q.dev_m};
      `TXDC_RCC_OFS:
        d.rdata = {2'b00, `TXDC_RSV_VAL, q.txoff};
      default:
        d.rdata = 8'h00;
    endcase
    // radio state walk
    case (q.st)
      txdc_pkg::TXDC_ST_IDLE:
      begin
        if (tx_start)
          d.st = txdc_pkg::TXDC_ST_TX;
      end
      txdc_pkg::TXDC_ST_SYNTH:
      begin
        if (tx_start)
          d.st = txdc_pkg::TXDC_ST_TX;
        else if (idle_cmd)
          d.st = txdc_pkg::TXDC_ST_IDLE;
      end
      txdc_pkg::TXDC_ST_TX:
      begin
        if (idle_cmd)
          d.st = txdc_pkg::TXDC_ST_IDLE;
        else if (pkt_done)
        begin
          case (q.txoff)
            txdc_pkg::TXDC_NXT_IDLE:
              d.st = txdc_pkg::TXDC_ST_IDLE;
            txdc_pkg::TXDC_NXT_SYNTH:
              d.st = txdc_pkg::TXDC_ST_SYNTH;
            txdc_pkg::TXDC_NXT_TX:
            begin
              d.st      = txdc_pkg::TXDC_ST_TX;
              d.pre_rst = 1'b1;
            end
            default:
              d.st = txdc_pkg::TXDC_ST_IDLE; // forbidden code, fall safe
          endcase
        end
      end
      default:
        d.st = txdc_pkg::TXDC_ST_IDLE;
    endcase
  end

  // state register with reset values
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q.dev_e   <= `TXDC_DEV_E_RST;
      q.dev_m   <= `TXDC_DEV_M_RST;
      q.txoff   <= `TXDC_TXOFF_RST;
      q.st      <= txdc_pkg::TXDC_ST_IDLE;
      q.pre_rst <= 1'b0;
      q.rdata   <= 8'h00;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign reg_rdata        = q.rdata;
  assign radio_state      = q.st;
  assign preamble_restart = q.pre_rst;
  assign dev_word         = cfg_if.dev_word;
  assign dev_active       = cfg_if.dev_active;
  assign msk_phase        = cfg_if.msk_phase;
  assign msk_ramp         = cfg_if.msk_ramp;

  default clocking cb @(posedge clk); endclocking

  // reset values of deviation fields
  property p_dev_rst;
    @(posedge clk) $fell(reset) |-> q.dev_e == `TXDC_DEV_E_RST && q.dev_m == `TXDC_DEV_M_RST;
  endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("deviation reset value wrong");

  // reset value and write of next-state field
  property p_txoff_rst;
    @(posedge clk) $fell(reset) |-> q.txoff == `TXDC_TXOFF_RST && q.st == txdc_pkg::TXDC_ST_IDLE;
  endproperty
  a_txoff_rst: assert property (p_txoff_rst) else $error("next-state reset value wrong");

  property p_txoff_wr;
    @(posedge clk) disable iff (reset)
    wr_rcc |=> q.txoff == $past(reg_wdata[`TXDC_TXOFF_LSB +: 2]) ##1 reg_rdata[1:0] == $past(q.txoff) || $past(reg_addr) != `TXDC_RCC_OFS;
  endproperty
  a_txoff_wr: assert property (p_txoff_wr) else $error("next-state write lost");

  // next-state field moves only on its own write
  property p_txoff_keep;
    @(posedge clk) disable iff (reset)
    !wr_rcc |=> $stable(q.txoff);
  endproperty
  a_txoff_keep: assert property (p_txoff_keep) else $error("next-state changed without write");

  // reserved field reads fixed value, never written
  property p_rsv_read;
    @(posedge clk) disable iff (reset)
    reg_addr == `TXDC_RCC_OFS ##1 !$past(reset) |-> reg_rdata[7:2] == {2'b00, `TXDC_RSV_VAL};
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved field read wrong");

  // packet end with 00 returns to idle
  property p_next_idle;
    @(posedge clk) disable iff (reset)
    q.st == txdc_pkg::TXDC_ST_TX && pkt_done && !idle_cmd && q.txoff == txdc_pkg::TXDC_NXT_IDLE
      |=> radio_state == txdc_pkg::TXDC_ST_IDLE && !preamble_restart;
  endproperty
  a_next_idle: assert property (p_next_idle) else $error("no return to idle");

  // packet end with 01 goes to synth-on-ready
  property p_next_synth;
    @(posedge clk) disable iff (reset)
    q.st == txdc_pkg::TXDC_ST_TX && pkt_done && !idle_cmd && q.txoff == txdc_pkg::TXDC_NXT_SYNTH
      |=> radio_state == txdc_pkg::TXDC_ST_SYNTH;
  endproperty
  a_next_synth: assert property (p_next_synth) else $error("no move to synth-on");

  // packet end with 10 stays in transmit with one restart pulse
  property p_stay_tx;
    @(posedge clk) disable iff (reset)
    q.st == txdc_pkg::TXDC_ST_TX && pkt_done && !idle_cmd && q.txoff == txdc_pkg::TXDC_NXT_TX
      |=> radio_state == txdc_pkg::TXDC_ST_TX && preamble_restart ##1 !preamble_restart || $past(pkt_done);
  endproperty
  a_stay_tx: assert property (p_stay_tx) else $error("transmit not kept");

  // gfsk format selects the fsk deviation word
  property p_fmt_decode;
    @(posedge clk) disable iff (reset)
    !reset && modulation_select == txdc_pkg::TXDC_MOD_GFSK |=> dev_active && dev_word != 11'h000;
  endproperty
  a_fmt_decode: assert property (p_fmt_decode) else $error("format decode wrong");

  // msk and ask formats give no fsk deviation word
  property p_no_dev;
    @(posedge clk) disable iff (reset)
    !reset && (modulation_select == txdc_pkg::TXDC_MOD_MSK || modulation_select == txdc_pkg::TXDC_MOD_ASK)
      |=> !dev_active && dev_word == 11'h000;
  endproperty
  a_no_dev: assert property (p_no_dev) else $error("deviation word outside fsk");

  // main scenarios
  c_restart: cover property (@(posedge clk) disable iff (reset) preamble_restart);
  c_synth: cover property (@(posedge clk) disable iff (reset) radio_state == txdc_pkg::TXDC_ST_SYNTH);
  c_msk_ramp: cover property (@(posedge clk) disable iff (reset) msk_ramp ##1 !msk_ramp);
  c_dev_write: cover property (@(posedge clk) disable iff (reset) wr_dev ##1 dev_active);
  c_tx_to_idle: cover property (@(posedge clk) disable iff (reset)
    radio_state == txdc_pkg::TXDC_ST_TX ##1 radio_state == txdc_pkg::TXDC_ST_IDLE);
endmodule

// ### bench/test_txdc_top.sv
// self-checking bench for the deviation and post-transmit configuration block
// assumes txdc_top plain ports, one 40 MHz clock, synchronous active-high reset
`timescale 1ns/10ps
module test_txdc_top;
  logic                  clk         = 1'b0;
  logic                  reset       = 1'b1;
  logic [5:0]            reg_addr    = 6'h00;
  logic                  reg_wr      = 1'b0;
  logic [7:0]            reg_wdata   = 8'h00;
  logic [7:0]            reg_rdata;
  logic [2:0]            mod_sel     = 3'h0;
  logic [4:0]            strobes     = 5'h00;
  logic                  data_bit    = 1'b0;
  txdc_pkg::txdc_state_t radio_state;
  logic                  preamble_restart;
  logic [10:0]           dev_word;
  logic                  dev_active;
  logic [1:0]            msk_phase;
  logic                  msk_ramp;
  int                    fail_count  = 0;
  int                    checked     = 0;

  // clock generator, 25 ns period
  always
  begin
    #12.5 clk = ~clk;
  end

  // device under test; strobes = {tx_start, idle_cmd, pkt_done, sym_tick, eighth_tick}
  txdc_top txdc_top_inst
  (
    .clk              (clk),
    .reset            (reset),
    .reg_addr         (reg_addr),
    .reg_wr           (reg_wr),
    .reg_wdata        (reg_wdata),
    .reg_rdata        (reg_rdata),
    .modulation_select(mod_sel),
    .tx_start         (strobes[4]),
    .idle_cmd         (strobes[3]),
    .pkt_done         (strobes[2]),
    .sym_tick         (strobes[1]),
    .eighth_tick      (strobes[0]),
    .data_bit         (data_bit),
    .radio_state      (radio_state),
    .preamble_restart (preamble_restart),
    .dev_word         (dev_word),
    .dev_active       (dev_active),
    .msk_phase        (msk_phase),
    .msk_ramp         (msk_ramp)
  );

  // compare one value and count
  task check(input logic [10:0] seen, input logic [10:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // wait n edges, then settle
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one register write, taken at the second edge
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // present address, read data one cycle later
  task rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    wt(1);
    check(reg_rdata, exp, "read data");
  endtask

  // one-cycle pulse on the selected strobes
  task pulse(input logic [4:0] p, input logic b);
    @(posedge clk);
    strobes  <= p;
    data_bit <= b;
    @(posedge clk);
    strobes <= 5'h00;
    #1;
  endtask

  // reset values of both registers and of the deviation word
  task test_reset;
    rd(6'h15, 8'h47);
    rd(6'h17, 8'h30);
    check(dev_word, 11'd240, "reset deviation");
    check(radio_state, txdc_pkg::TXDC_ST_IDLE, "reset state");
  endtask

  // read-only bits, writable fields, unmapped address
  task test_regs;
    wr(6'h15, 8'hff);
    rd(6'h15, 8'h77);
    wr(6'h17, 8'hfe);
    rd(6'h17, 8'h32);
    wr(6'h17, 8'h00);
    rd(6'h17, 8'h30);
    rd(6'h16, 8'h00);
  endtask

  // deviation word for fsk and gfsk, ignored for ask
  task test_dev;
    logic [2:0] ev [3];
    logic [2:0] mv [3];
    ev = '{3'h0, 3'h3, 3'h7};
    mv = '{3'h0, 3'h5, 3'h7};
    for (int i = 0; i < 3; i++)
    begin
      wr(6'h15, {1'b0, ev[i], 1'b0, mv[i]});
      for (int k = 0; k < 3; k++)
      begin
        @(posedge clk);
        mod_sel <= (k == 0) ? 3'h0 : (k == 1) ? 3'h1 : 3'h3;
        wt(2);
        check(dev_word, (k == 2) ? 11'd0 : (11'd8 + mv[i]) << ev[i], "deviation word");
        check(dev_active, (k == 2) ? 11'd0 : 11'd1, "deviation active");
      end
      pulse(5'h02, 1'b0);
      check(msk_phase, 11'd0, "ask phase unchanged");
    end
  endtask

  // next state after packet end for field values 00, 01 and 10
  task test_state;
    txdc_pkg::txdc_state_t exp_st [3];
    exp_st = '{txdc_pkg::TXDC_ST_IDLE, txdc_pkg::TXDC_ST_SYNTH, txdc_pkg::TXDC_ST_TX};
    pulse(5'h04, 1'b0);
    check(radio_state, txdc_pkg::TXDC_ST_IDLE, "packet end outside transmit");
    for (int n = 0; n < 3; n++)
    begin
      wr(6'h17, 8'(n));
      pulse(5'h10, 1'b0);
      check(radio_state, txdc_pkg::TXDC_ST_TX, "enter transmit");
      pulse(5'h04, 1'b0);
      check(radio_state, exp_st[n], "state after packet");
      check(preamble_restart, (n == 2) ? 11'd1 : 11'd0, "preamble restart");
      wt(1);
      check(preamble_restart, 11'd0, "restart pulse length");
      pulse(5'h08, 1'b0);
      check(radio_state, txdc_pkg::TXDC_ST_IDLE, "back to idle");
    end
  endtask

  // msk phase steps and ramp length from the mantissa
  task test_msk;
    wr(6'h15, 8'h41);
    @(posedge clk);
    mod_sel <= 3'h7;
    wt(2);
    check(dev_active, 11'd0, "msk no deviation");
    pulse(5'h02, 1'b0);
    check(msk_phase, 11'd1, "zero bit phase");
    check(msk_ramp, 11'd1, "ramp at symbol start");
    pulse(5'h01, 1'b0);
    check(msk_ramp, 11'd1, "ramp after one eighth");
    pulse(5'h01, 1'b0);
    check(msk_ramp, 11'd0, "ramp ends after two eighths");
    pulse(5'h02, 1'b1);
    check(msk_phase, 11'd0, "one bit phase");
    check(msk_ramp, 11'd1, "ramp restarts at symbol");
    pulse(5'h02, 1'b1);
    check(msk_phase, 11'd3, "phase wraps down");
  endtask

  // verdict and end of run
  task results;
    $display("checked %0d, fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wt(2);
    test_reset;
    test_regs;
    test_dev;
    test_state;
    test_msk;
    results;
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end
endmodule
